// *** logic/tsr_pkg.sv ***
// Package with register map, field positions and types of the result block.
package tsr_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] TSR_CFG_ADDR   = 8'h01;
    localparam logic [7:0] TSR_RES_ADDR   = 8'h02;
    localparam logic [7:0] TSR_ID_ADDR    = 8'h03;
    localparam logic [7:0] TSR_CRIT_ADDR  = 8'h04;
    localparam logic [7:0] TSR_HIGH_ADDR  = 8'h06;
    localparam logic [7:0] TSR_LOW_ADDR   = 8'h07;

    // ==========================================================
    // Configuration field positions
    localparam int TSR_CFG_RES_BIT   = 7;
    localparam int TSR_CFG_MODE_BIT  = 4;
    localparam int TSR_CFG_LPOL_BIT  = 3;
    localparam int TSR_CFG_CPOL_BIT  = 2;
    localparam int TSR_CFG_FQ_HI     = 1;

    // ==========================================================
    // Result flag positions in 13-bit mode
    localparam int TSR_FLAG_CRIT_BIT = 2;
    localparam int TSR_FLAG_HIGH_BIT = 1;
    localparam int TSR_FLAG_LOW_BIT  = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  TSR_CFG_RST    = 8'h00;
    localparam logic [15:0] TSR_RES_RST    = 16'h0000;
    localparam logic [15:0] TSR_CRIT_RST   = 16'h4980;
    localparam logic [15:0] TSR_HIGH_RST   = 16'h2000;
    localparam logic [15:0] TSR_LOW_RST    = 16'h0500;

    // Identification codes; the values are arbitrary.
    localparam logic [4:0]  TSR_MAKER_ID   = 5'h0a;
    localparam logic [2:0]  TSR_REV_ID     = 3'h1;

    // ==========================================================
    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tsr_req_t;

    // Completed conversion from the converter
    typedef struct packed {
        logic [15:0] value;
        logic        valid;
    } tsr_conv_t;

endpackage

// *** logic/tsr_regs.sv ***
// Result, alarm and configuration register block of the temperature sensor.
//
// Summary of operation
// (RULE1) Config bit 4 picks latched interrupt (0) or comparator (1) pins.
// (RULE2) Config bit 3 sets limit alarm pin polarity; 1 high, reset 0.
// (RULE3) Config bit 2 sets critical alarm pin polarity; 1 high, reset 0.
// (RULE4) Config bits 1:0 set consecutive faults needed: one to four.
// (RULE5) A non-faulting conversion clears the consecutive fault count.
// (RULE6) Result is read-only 16-bit two's complement at 0x02.
// (RULE7) Config bit 7 selects 13-bit or 16-bit result format.
// (RULE8) Step is 0.0625 C in 13-bit, 0.0078 C in 16-bit mode.
// (RULE9) Result bit 15 is the sign, 1 meaning negative.
// (RULE10) In 13-bit mode result bits 2:0 are critical, high, low flags.
// (RULE11) In 16-bit mode result bits 2:0 are extended value bits.
// (RULE12) 13-bit mode: bit 2 set when value above critical limit.
// (RULE13) 13-bit mode: bit 1 set when value above high limit.
// (RULE14) 13-bit mode: bit 0 set when value below low limit.
// (RULE15) Read-only ID at 0x03: maker code 7:3, revision 2:0.
// (RULE16) Writable critical limit at 0x04, two's complement, sign at MSB.
// (RULE17) Critical event when result strictly greater than critical limit.
// (RULE18) Critical pin goes active on critical event, after queue, polarity.
// (RULE19) Critical limit resets to the code for +147 C.
// (RULE20) Critical limit reset code is 0x4980.
// (RULE21) Result reads zero after reset until first conversion completes.
`timescale 1ns/1ps

module tsr_regs
    import tsr_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire tsr_pkg::tsr_req_t req_i,
    output logic [15:0]            rdata_o,
    // Converter result
    input  wire tsr_pkg::tsr_conv_t conv_i,
    // Alarm pins, open drain
    output logic                   limit_alarm_pin_o,
    output logic                   limit_alarm_pin_oe_o,
    output logic                   critical_alarm_pin_o,
    output logic                   critical_alarm_pin_oe_o
);

    // ==========================================================
    // Declarations
    logic [7:0]  cfg_reg;
    logic [15:0] res_reg;
    logic [15:0] crit_reg;
    logic [15:0] high_reg;
    logic [15:0] low_reg;
    logic [2:0]  crit_cnt_reg;
    logic [2:0]  lim_cnt_reg;
    logic        crit_act_reg;
    logic        lim_act_reg;
    logic [2:0]  fq_need;
    logic        crit_fault;
    logic        lim_fault;
    logic        high_fault;
    logic        low_fault;
    logic        hi_res;
    logic        cmp_mode;
    logic [15:0] rdata_next;

    // Signed compare of the temperature part; 13-bit mode ignores bits 2:0.
    function automatic logic sgt(input logic [15:0] a,
                                 input logic [15:0] b,
                                 input logic        full);
        logic [15:0] am;
        logic [15:0] bm;
        am = full ? a : {a[15:3], 3'h0};
        bm = full ? b : {b[15:3], 3'h0};
        sgt = $signed(am) > $signed(bm);
    endfunction

    // ==========================================================
    // Configuration register and limits
    assign hi_res   = cfg_reg[TSR_CFG_RES_BIT]; // RULE7
    assign cmp_mode = cfg_reg[TSR_CFG_MODE_BIT]; // RULE1
    assign fq_need  = {1'b0, cfg_reg[TSR_CFG_FQ_HI:0]} + 3'h1; // RULE4

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cfg_reg  <= TSR_CFG_RST;
            crit_reg <= TSR_CRIT_RST; // RULE19 RULE20
            high_reg <= TSR_HIGH_RST;
            low_reg  <= TSR_LOW_RST;
        end
        else if (req_i.wr)
        begin
            case (req_i.addr)
                TSR_CFG_ADDR:  cfg_reg  <= req_i.wdata[7:0];
                TSR_CRIT_ADDR: crit_reg <= req_i.wdata; // RULE16
                TSR_HIGH_ADDR: high_reg <= req_i.wdata;
                TSR_LOW_ADDR:  low_reg  <= req_i.wdata;
                default:       cfg_reg  <= cfg_reg;
            endcase
        end
    end

    // ==========================================================
    // Fault detection on the incoming conversion
    assign crit_fault = sgt(conv_i.value, crit_reg, hi_res); // RULE17
    assign high_fault = sgt(conv_i.value, high_reg, hi_res);
    assign low_fault  = sgt(low_reg, conv_i.value, hi_res);
    assign lim_fault  = high_fault | low_fault;

    // ==========================================================
    // Temperature result register
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            res_reg <= TSR_RES_RST; // RULE21
        else if (conv_i.valid)
        begin
            if (hi_res)
                res_reg <= conv_i.value; // RULE6 RULE8 RULE9 RULE11
            else
                res_reg <= {conv_i.value[15:3], // RULE10
                            crit_fault, // RULE12
                            high_fault, // RULE13
                            low_fault}; // RULE14
        end
    end

    // ==========================================================
    // Fault queues
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            crit_cnt_reg <= 3'h0;
            lim_cnt_reg  <= 3'h0;
        end
        else if (conv_i.valid)
        begin
            if (!crit_fault)
                crit_cnt_reg <= 3'h0; // RULE5
            else if (crit_cnt_reg < 3'h4)
                crit_cnt_reg <= crit_cnt_reg + 3'h1; // RULE4
            if (!lim_fault)
                lim_cnt_reg <= 3'h0; // RULE5
            else if (lim_cnt_reg < 3'h4)
                lim_cnt_reg <= lim_cnt_reg + 3'h1; // RULE4
        end
    end

    // ==========================================================
    // Alarm state: comparator follows, interrupt holds until a register read in a cycle without a valid conversion
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            crit_act_reg <= 1'b0;
            lim_act_reg  <= 1'b0;
        end
        else if (conv_i.valid)
        begin
            if (crit_fault && (crit_cnt_reg + 3'h1 >= fq_need))
                crit_act_reg <= 1'b1; // RULE18
            else if (!crit_fault && cmp_mode)
                crit_act_reg <= 1'b0; // RULE1
            if (lim_fault && (lim_cnt_reg + 3'h1 >= fq_need))
                lim_act_reg <= 1'b1; // RULE4
            else if (!lim_fault && cmp_mode)
                lim_act_reg <= 1'b0; // RULE1
        end
        else if (req_i.rd && !cmp_mode)
        begin
            // Any register read in a cycle without a valid conversion releases a latched interrupt.
            crit_act_reg <= 1'b0; // RULE1
            lim_act_reg  <= 1'b0;
        end
    end

    // ==========================================================
    // Pin drive: an active-high pin releases when active, low drives.
    assign critical_alarm_pin_o    = 1'b0;
    assign critical_alarm_pin_oe_o =
        crit_act_reg ^ cfg_reg[TSR_CFG_CPOL_BIT]; // RULE3
    assign limit_alarm_pin_o       = 1'b0;
    assign limit_alarm_pin_oe_o    =
        lim_act_reg ^ cfg_reg[TSR_CFG_LPOL_BIT]; // RULE2

    // ==========================================================
    // Read path
    always_comb
    begin
        case (req_i.addr)
            TSR_CFG_ADDR:  rdata_next = {8'h00, cfg_reg};
            TSR_RES_ADDR:  rdata_next = res_reg; // RULE6
            TSR_ID_ADDR:
                rdata_next = {8'h00, TSR_MAKER_ID, TSR_REV_ID}; // RULE15
            TSR_CRIT_ADDR: rdata_next = crit_reg;
            TSR_HIGH_ADDR: rdata_next = high_reg;
            TSR_LOW_ADDR:  rdata_next = low_reg;
            default:       rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            rdata_o <= 16'h0000;
        else if (req_i.rd)
            rdata_o <= rdata_next;
        else
            rdata_o <= 16'h0000;
    end

    // ==========================================================
    // Assertions
    crit_reset_a : assert property (@(posedge sys_clk_i) // RULE20
        $fell(rst_i) |-> crit_reg == 16'h4980)
        else $error("critical limit reset code wrong");
    res_reset_a : assert property (@(posedge sys_clk_i) // RULE21
        disable iff (rst_i) $fell(rst_i) |-> res_reg == 16'h0000)
        else $error("result not zero after reset");
    res_load_a : assert property (@(posedge sys_clk_i) // RULE11
        disable iff (rst_i) conv_i.valid && hi_res
        |=> res_reg == $past(conv_i.value))
        else $error("16-bit result not loaded");
    flag_crit_a : assert property (@(posedge sys_clk_i) // RULE12
        disable iff (rst_i) conv_i.valid && !hi_res
        |=> res_reg[2] == $past(crit_fault))
        else $error("critical flag wrong");
    flag_high_a : assert property (@(posedge sys_clk_i) // RULE13
        disable iff (rst_i) conv_i.valid && !hi_res
        |=> res_reg[1] == $past(high_fault))
        else $error("high flag wrong");
    flag_low_a : assert property (@(posedge sys_clk_i) // RULE14
        disable iff (rst_i) conv_i.valid && !hi_res
        |=> res_reg[0] == $past(low_fault))
        else $error("low flag wrong");
    queue_clear_a : assert property (@(posedge sys_clk_i) // RULE5
        disable iff (rst_i) conv_i.valid && !crit_fault
        |=> crit_cnt_reg == 3'h0)
        else $error("fault count not cleared");
    crit_pol_a : assert property (@(posedge sys_clk_i) // RULE3
        disable iff (rst_i) critical_alarm_pin_oe_o
        == (crit_act_reg != cfg_reg[2]))
        else $error("critical pin polarity wrong");
    lim_pol_a : assert property (@(posedge sys_clk_i) // RULE2
        disable iff (rst_i) limit_alarm_pin_oe_o
        == (lim_act_reg != cfg_reg[3]))
        else $error("limit pin polarity wrong");
    single_fault_a : assert property (@(posedge sys_clk_i) // RULE18
        disable iff (rst_i) conv_i.valid && crit_fault
        && cfg_reg[1:0] == 2'h0 |=> crit_act_reg)
        else $error("critical alarm not raised");
    cmp_release_a : assert property (@(posedge sys_clk_i) // RULE1
        disable iff (rst_i) conv_i.valid && !crit_fault && cmp_mode
        |=> !crit_act_reg)
        else $error("comparator mode did not release");
    id_read_a : assert property (@(posedge sys_clk_i) // RULE15
        disable iff (rst_i) req_i.rd && req_i.addr == 8'h03
        |=> rdata_o[7:0] == {TSR_MAKER_ID, TSR_REV_ID})
        else $error("identification read wrong");

    // ==========================================================
    // Register port assertions
    rdata_idle_a : assert property (@(posedge sys_clk_i) // RULE6
        disable iff (rst_i) !req_i.rd |=> rdata_o == 16'h0000)
        else $error("read data did not return to zero");

    id_upper_a : assert property (@(posedge sys_clk_i) // RULE15
        disable iff (rst_i) req_i.rd && req_i.addr == TSR_ID_ADDR
        |=> rdata_o[15:8] == 8'h00)
        else $error("identification upper byte not zero");

    res_read_a : assert property (@(posedge sys_clk_i) // RULE6
        disable iff (rst_i) req_i.rd && req_i.addr == TSR_RES_ADDR
        |=> rdata_o == $past(res_reg))
        else $error("result read wrong");

    crit_read_a : assert property (@(posedge sys_clk_i) // RULE16
        disable iff (rst_i) req_i.rd && req_i.addr == TSR_CRIT_ADDR
        |=> rdata_o == $past(crit_reg))
        else $error("critical limit read wrong");

    cfg_read_a : assert property (@(posedge sys_clk_i) // RULE7
        disable iff (rst_i) req_i.rd && req_i.addr == TSR_CFG_ADDR
        |=> rdata_o == {8'h00, $past(cfg_reg)})
        else $error("configuration read wrong");

    crit_write_a : assert property (@(posedge sys_clk_i) // RULE16
        disable iff (rst_i) req_i.wr && req_i.addr == TSR_CRIT_ADDR
        |=> crit_reg == $past(req_i.wdata))
        else $error("critical limit write lost");

    cfg_write_a : assert property (@(posedge sys_clk_i) // RULE1
        disable iff (rst_i) req_i.wr && req_i.addr == TSR_CFG_ADDR
        |=> cfg_reg == $past(req_i.wdata[7:0]))
        else $error("configuration write lost");

    high_write_a : assert property (@(posedge sys_clk_i) // RULE13
        disable iff (rst_i) req_i.wr && req_i.addr == TSR_HIGH_ADDR
        |=> high_reg == $past(req_i.wdata))
        else $error("high limit write lost");

    low_write_a : assert property (@(posedge sys_clk_i) // RULE14
        disable iff (rst_i) req_i.wr && req_i.addr == TSR_LOW_ADDR
        |=> low_reg == $past(req_i.wdata))
        else $error("low limit write lost");

    // ==========================================================
    // Result register assertions
    res_hold_a : assert property (@(posedge sys_clk_i) // RULE6
        disable iff (rst_i) !conv_i.valid |=> $stable(res_reg))
        else $error("result changed without conversion");

    res_upper_a : assert property (@(posedge sys_clk_i) // RULE10
        disable iff (rst_i) conv_i.valid && !hi_res
        |=> res_reg[15:3] == $past(conv_i.value[15:3]))
        else $error("13-bit result value wrong");

    res_sign_a : assert property (@(posedge sys_clk_i) // RULE9
        disable iff (rst_i) conv_i.valid
        |=> res_reg[15] == $past(conv_i.value[15]))
        else $error("result sign wrong");

    // ==========================================================
    // Fault queue and alarm assertions
    cnt_limit_a : assert property (@(posedge sys_clk_i) // RULE4
        disable iff (rst_i) crit_cnt_reg <= 3'h4 && lim_cnt_reg <= 3'h4)
        else $error("fault count beyond four");

    lim_clear_a : assert property (@(posedge sys_clk_i) // RULE5
        disable iff (rst_i) conv_i.valid && !lim_fault
        |=> lim_cnt_reg == 3'h0)
        else $error("limit fault count not cleared");

    lim_single_a : assert property (@(posedge sys_clk_i) // RULE4
        disable iff (rst_i) conv_i.valid && lim_fault
        && cfg_reg[1:0] == 2'h0 |=> lim_act_reg)
        else $error("limit alarm not raised");

    lim_release_a : assert property (@(posedge sys_clk_i) // RULE1
        disable iff (rst_i) conv_i.valid && !lim_fault && cmp_mode
        |=> !lim_act_reg)
        else $error("limit comparator did not release");

    queue_wait_a : assert property (@(posedge sys_clk_i) // RULE4
        disable iff (rst_i) conv_i.valid && !crit_act_reg
        && (crit_cnt_reg + 3'h1 < fq_need) |=> !crit_act_reg)
        else $error("critical alarm before queue filled");

    latch_hold_a : assert property (@(posedge sys_clk_i) // RULE1
        disable iff (rst_i) !conv_i.valid && !req_i.rd && crit_act_reg
        |=> crit_act_reg)
        else $error("critical alarm dropped on its own");

    latch_clear_a : assert property (@(posedge sys_clk_i) // RULE1
        disable iff (rst_i) !conv_i.valid && req_i.rd && !cmp_mode
        |=> !crit_act_reg && !lim_act_reg)
        else $error("read did not release latched alarm");

    crit_alarm_c : cover property (@(posedge sys_clk_i)
        disable iff (rst_i) $rose(crit_act_reg));
    queue_four_c : cover property (@(posedge sys_clk_i)
        disable iff (rst_i) crit_cnt_reg == 3'h4);
    hires_c : cover property (@(posedge sys_clk_i)
        disable iff (rst_i) conv_i.valid && hi_res);
    latch_clear_c : cover property (@(posedge sys_clk_i)
        disable iff (rst_i) $fell(lim_act_reg) && !cmp_mode);

endmodule

// *** tb/tsr_host.sv ***
// Host model that reaches the result block over its register port.
`timescale 1ns/1ps

module tsr_host
    import tsr_pkg::*;
(
    // Clock
    input  wire logic              sys_clk_i,
    // Register port
    output tsr_pkg::tsr_req_t      req_o,
    input  wire logic [15:0]       rdata_i
);
    initial req_o = '0;

    // ==========================================================
    // Bus cycles; a released address and data show inverted values.
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        req_o <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_i);
        req_o <= '{~a, ~d, 1'b0, 1'b0};
        #1;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        req_o <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge sys_clk_i);
        req_o <= '{~a, 16'hffff, 1'b0, 1'b0};
        #1;
        d = rdata_i;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the result, alarm and configuration registers.
`timescale 1ns/1ps

module testbench;
    import tsr_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    tsr_conv_t   conv = '0;
    tsr_req_t    req;
    logic [15:0] rdata;
    logic [15:0] rd;
    logic        lim_o;
    logic        lim_oe;
    logic        crit_o;
    logic        crit_oe;
    int          errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    // Open-drain pins with pull-ups.
    wire         lim_pin = lim_oe ? lim_o : 1'b1;
    wire         crit_pin = crit_oe ? crit_o : 1'b1;

    always #2.5 clk = ~clk;

    tsr_regs tsr_regs_i (
        .sys_clk_i               (clk),
        .rst_i                   (rst),
        .req_i                   (req),
        .rdata_o                 (rdata),
        .conv_i                  (conv),
        .limit_alarm_pin_o       (lim_o),
        .limit_alarm_pin_oe_o    (lim_oe),
        .critical_alarm_pin_o    (crit_o),
        .critical_alarm_pin_oe_o (crit_oe)
    );

    tsr_host tsr_host_i (
        .sys_clk_i (clk),
        .req_o     (req),
        .rdata_i   (rdata)
    );

    // ==========================================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] e);
        check_count++;
        if (seen !== e)
        begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, e);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        tsr_host_i.read_reg(a, rd);
        check(rd, e);
    endtask

    task automatic convert(input logic [15:0] v);
        @(posedge clk);
        conv <= '{v, 1'b1};
        @(posedge clk);
        conv <= '{~v, 1'b0};
        #1;
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            errors++;
            wrap_up();
        end
    end

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rdchk(TSR_CFG_ADDR, 16'h0000);
        rdchk(TSR_RES_ADDR, 16'h0000);
        rdchk(TSR_ID_ADDR, {8'h00, TSR_MAKER_ID, TSR_REV_ID});
        rdchk(TSR_CRIT_ADDR, 16'h4980);
        rdchk(8'h05, 16'h0000);
        rdchk(TSR_HIGH_ADDR, 16'h2000);
        rdchk(TSR_LOW_ADDR, 16'h0500);
        @(posedge clk);
        #1;
        check(rdata, 16'h0000);
        check(16'({lim_pin, crit_pin}), 16'h0003);
        tsr_host_i.write_reg(TSR_RES_ADDR, 16'hffff);
        tsr_host_i.write_reg(TSR_ID_ADDR, 16'hffff);
        rdchk(TSR_RES_ADDR, 16'h0000);
        rdchk(TSR_ID_ADDR, {8'h00, TSR_MAKER_ID, TSR_REV_ID});
    endtask

    task automatic t_format;
        convert(16'h4a00);
        rdchk(TSR_RES_ADDR, 16'h4a06);
        convert(16'h4980);
        rdchk(TSR_RES_ADDR, 16'h4982);
        convert(16'h0107);
        rdchk(TSR_RES_ADDR, 16'h0101);
        tsr_host_i.write_reg(TSR_CFG_ADDR, 16'h0080);
        rdchk(TSR_CFG_ADDR, 16'h0080);
        convert(16'h1235);
        rdchk(TSR_RES_ADDR, 16'h1235);
        convert(16'hf001);
        rdchk(TSR_RES_ADDR, 16'hf001);
    endtask

    task automatic t_queue;
        for (int q = 0; q < 4; q++)
        begin
            do_reset();
            tsr_host_i.write_reg(TSR_CFG_ADDR, 16'(8'h10 | q));
            repeat (q) convert(16'h4a00);
            convert(16'h1000);
            repeat (q) convert(16'h4a00);
            check(16'(crit_pin), 16'h0001);
            convert(16'h4a00);
            check(16'({lim_pin, crit_pin}), 16'h0000);
            convert(16'h1000);
            check(16'({lim_pin, crit_pin}), 16'h0003);
        end
    endtask

    task automatic t_latch;
        do_reset();
        convert(16'h4a00);
        check(16'(crit_pin), 16'h0000);
        convert(16'h1000);
        check(16'({lim_pin, crit_pin}), 16'h0000);
        rdchk(TSR_CFG_ADDR, 16'h0000);
        check(16'({lim_pin, crit_pin}), 16'h0003);
    endtask

    task automatic t_polarity;
        do_reset();
        tsr_host_i.write_reg(TSR_CFG_ADDR, 16'h001c);
        check(16'(lim_pin), 16'h0000);
        check(16'(crit_pin), 16'h0000);
        convert(16'h4a00);
        check(16'({lim_pin, crit_pin}), 16'h0003);
    endtask

    task automatic t_crit;
        do_reset();
        tsr_host_i.write_reg(TSR_CFG_ADDR, 16'h0090);
        tsr_host_i.write_reg(TSR_CRIT_ADDR, 16'h0100);
        rdchk(TSR_CRIT_ADDR, 16'h0100);
        convert(16'h0100);
        check(16'(crit_pin), 16'h0001);
        convert(16'h0101);
        check(16'(crit_pin), 16'h0000);
        tsr_host_i.write_reg(TSR_CRIT_ADDR, 16'hff00);
        convert(16'hfe00);
        check(16'(crit_pin), 16'h0001);
        convert(16'h0010);
        check(16'(crit_pin), 16'h0000);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_format();
        t_queue();
        t_latch();
        t_polarity();
        t_crit();
        wrap_up();
    end
endmodule
